// file: hw/swc_pkg.sv
// Shared constants and types of the switch host chunk and forwarding configuration block.
package swc_pkg;
  localparam int unsigned FILL_W = 12;
  localparam int unsigned CNT_W = 8;
  localparam logic [5:0] IDX_CAP = 6'h02;
  localparam logic [5:0] IDX_CHUNK = 6'h04;
  localparam logic [5:0] IDX_CFG3 = 6'h05;
  localparam logic [5:0] IDX_CFG2 = 6'h06;
  localparam logic [5:0] IDX_STAT = 6'h07;
  localparam int unsigned CFG2_GAP2 = 16;
  localparam int unsigned CFG2_ORDER = 15;
  localparam int unsigned CFG2_U2P1 = 4;
  localparam int unsigned CFG2_U1P2 = 3;
  localparam int unsigned CFG2_U2CPU = 2;
  localparam logic [31:0] CFG2_RST = 32'h0000_0800;
  localparam logic [31:0] CFG2_WMASK = 32'h0001_FFFF;
  localparam int unsigned CFG3_U1CPU = 2;
  localparam logic [31:0] CFG3_RST = 32'h0000_0000;
  localparam logic [31:0] CFG3_WMASK = 32'h0000_0004;
  localparam int unsigned CHUNK_SEL_LSB = 0;
  localparam logic [2:0] CHUNK_SEL_MIN = 3'h3;
  localparam logic [2:0] CHUNK_SEL_MAX = 3'h6;
  localparam logic [2:0] CHUNK_SEL_RST = 3'h6;
  localparam int unsigned CAP_MIN_LSB = 0;
  localparam int unsigned STAT_LAST = 0;
  localparam int unsigned STAT_ACTIVE = 1;
  localparam int unsigned STAT_DROP1_LSB = 8;
  localparam int unsigned STAT_DROP2_LSB = 16;
  localparam int unsigned STAT_GAPREJ_LSB = 24;

  typedef enum logic {SWC_PORT1, SWC_PORT2} swc_port_t;

  typedef struct packed {
    logic [1:0] hi_rdy;
    logic [1:0] lo_rdy;
    logic [1:0][FILL_W-1:0] hi_fill;
    logic [1:0][FILL_W-1:0] lo_fill;
  } swc_rxq_t;

  typedef struct packed {
    logic valid;
    swc_port_t port;
    logic unknown;
    logic gap_err;
  } swc_frm_t;

  typedef struct packed {
    logic valid;
    logic gap_rej;
    logic drop;
    logic to_other;
    logic to_cpu_lo;
  } swc_dec_t;

  typedef struct packed {
    logic valid;
    swc_port_t port;
    logic high;
  } swc_sel_t;
endpackage : swc_pkg

// file: hw/swc_arb.sv
// Receive FIFO read-order arbiter between the two ports.
`timescale 1ns/1ps
`default_nettype none
module swc_arb
  import swc_pkg::*;
(
  input wire logic i_clk, // System clock.
  input wire logic i_reset_n, // Asynchronous reset, active low.
  input wire swc_rxq_t i_rxq, // Per-port, per-priority frame ready and fill level.
  input wire logic i_ping_pong, // Read order: 1 alternates ports, 0 follows fill level.
  input wire logic i_next, // Pulse: host side is ready to start the next frame.
  output swc_sel_t o_sel, // Registered selection, valid for one cycle.
  output swc_port_t o_last // Port served last.
);
  // Chooses between two ready ports at one priority level.
  function automatic swc_port_t pick(input logic [1:0] rdy,
                                     input logic [1:0][FILL_W-1:0] fill,
                                     input logic pp, input swc_port_t last);
    swc_port_t p;
    p = SWC_PORT1;
    if (rdy == 2'h2) begin
      p = SWC_PORT2;
    end else if (rdy == 2'h3) begin
      if (pp) begin
        p = (last == SWC_PORT1) ? SWC_PORT2 : SWC_PORT1;
      end else if (fill[1] > fill[0]) begin
        p = SWC_PORT2;
      end
    end
    return p;
  endfunction : pick

  swc_sel_t sel_d, sel_q;
  swc_port_t last_d, last_q;

  always_comb begin
    sel_d = '0;
    last_d = last_q;
    if (i_next && (|i_rxq.hi_rdy)) begin
      sel_d.valid = 1'b1;
      sel_d.high = 1'b1;
      sel_d.port = pick(i_rxq.hi_rdy, i_rxq.hi_fill, i_ping_pong, last_q);
      last_d = sel_d.port;
    end else if (i_next && (|i_rxq.lo_rdy)) begin
      sel_d.valid = 1'b1;
      sel_d.port = pick(i_rxq.lo_rdy, i_rxq.lo_fill, i_ping_pong, last_q);
      last_d = sel_d.port;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_q <= '0;
      last_q <= SWC_PORT2;
    end else begin
      sel_q <= sel_d;
      last_q <= last_d;
    end
  end

  assign o_sel = sel_q;
  assign o_last = last_q;
endmodule : swc_arb
`default_nettype wire

// file: hw/swc_fwd.sv
// Admission and unknown-destination forwarding decision for one received frame.
`timescale 1ns/1ps
`default_nettype none
module swc_fwd
  import swc_pkg::*;
(
  input wire logic i_clk, // System clock.
  input wire logic i_reset_n, // Asynchronous reset, active low.
  input wire swc_frm_t i_frm, // Frame event from a port MAC.
  input wire logic i_gap2_admit, // Admit gap-error frames on port 2.
  input wire logic i_u1p2, // Port 1 unknown frames to port 2.
  input wire logic i_u2p1, // Port 2 unknown frames to port 1.
  input wire logic i_u1cpu, // Port 1 unknown frames to host.
  input wire logic i_u2cpu, // Port 2 unknown frames to host.
  output swc_dec_t o_dec // Registered decision, valid for one cycle.
);
  swc_dec_t dec_d, dec_q;
  logic is_p2;

  always_comb begin
    dec_d = '0;
    is_p2 = (i_frm.port == SWC_PORT2);
    dec_d.valid = i_frm.valid;
    if (i_frm.valid && is_p2 && i_frm.gap_err && !i_gap2_admit) begin
      dec_d.gap_rej = 1'b1;
      dec_d.drop = 1'b1;
    end else if (i_frm.valid && i_frm.unknown) begin
      dec_d.to_other = is_p2 ? i_u2p1 : i_u1p2;
      dec_d.to_cpu_lo = is_p2 ? i_u2cpu : i_u1cpu;
      dec_d.drop = !dec_d.to_other && !dec_d.to_cpu_lo;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dec_q <= '0;
    end else begin
      dec_q <= dec_d;
    end
  end

  assign o_dec = dec_q;
endmodule : swc_fwd
`default_nettype wire

// file: hw/swc_top.sv
// Top of the switch host chunk and forwarding configuration block with its Wishbone registers.
`timescale 1ns/1ps
`default_nettype none
module swc_top
  import swc_pkg::*;
(
  input wire logic i_clk, // System clock, 200 MHz.
  input wire logic i_reset_n, // Asynchronous reset, active low.
  input wire logic i_wb_cyc, // Wishbone cycle.
  input wire logic i_wb_stb, // Wishbone strobe.
  input wire logic i_wb_we, // Wishbone write enable.
  input wire logic [7:0] i_wb_adr, // Wishbone byte address.
  input wire logic [3:0] i_wb_sel, // Wishbone byte enables.
  input wire logic [31:0] i_wb_dat, // Wishbone write data.
  output logic [31:0] o_wb_dat, // Wishbone read data.
  output logic o_wb_ack, // Wishbone acknowledge.
  input wire logic i_generic_spi, // High when the generic SPI protocol is in use.
  input wire swc_rxq_t i_rxq, // Receive FIFO ready flags and fill levels.
  input wire logic i_rx_next, // Pulse: start of the next frame toward the host.
  output swc_sel_t o_rx_sel, // Chosen FIFO for that frame.
  input wire swc_frm_t i_frm, // Received frame event.
  output swc_dec_t o_dec, // Forwarding decision for that frame.
  output logic [6:0] o_chunk_bytes, // Chunk payload bytes, zero in generic SPI.
  output logic o_chunk_active, // Chunked protocol in use.
  output logic o_port2_admit_gap_error_frames // Port 2 MAC admits gap-error frames.
);
  // Decodes a word index from a byte address.
  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    return (adr[7:2] == idx);
  endfunction : hit

  // Merges write data into a register under byte enables and a writable mask.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0] sel,
                                        input logic [31:0] mask);
    logic [31:0] be;
    be = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~(be & mask)) | (wdat & be & mask);
  endfunction : merge

  // Bus slave state.
  logic req;
  logic wr_go;
  logic ack_d, ack_q;
  logic [31:0] rdat_d, rdat_q;

  // Configuration state.
  logic [31:0] cfg2_d, cfg2_q;
  logic [31:0] cfg3_d, cfg3_q;
  logic [2:0] chunk_sel_d, chunk_sel_q;
  logic [2:0] chunk_sel_wr;
  logic [6:0] bytes_d, bytes_q;
  logic active_d, active_q;
  logic gap2_d, gap2_q;

  // Status counters.
  logic [CNT_W-1:0] gaprej_d, gaprej_q;
  logic [1:0][CNT_W-1:0] drop_cnt;

  swc_sel_t sel;
  swc_port_t last;
  swc_dec_t dec;
  logic [31:0] stat;
  logic [31:0] cap;

  assign req = i_wb_cyc && i_wb_stb;
  assign wr_go = req && i_wb_we && !ack_q;

  always_comb begin
    ack_d = req && !ack_q;
    rdat_d = rdat_q;
    if (req && !ack_q) begin
      rdat_d = 32'h0000_0000;
      if (!i_wb_we) begin
        if (hit(i_wb_adr, IDX_CAP)) begin
          rdat_d = cap;
        end else if (hit(i_wb_adr, IDX_CHUNK)) begin
          rdat_d[CHUNK_SEL_LSB +: 3] = chunk_sel_q;
        end else if (hit(i_wb_adr, IDX_CFG3)) begin
          rdat_d = cfg3_q;
        end else if (hit(i_wb_adr, IDX_CFG2)) begin
          rdat_d = cfg2_q;
        end else if (hit(i_wb_adr, IDX_STAT)) begin
          rdat_d = stat;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // The smallest supported selector value is fixed in hardware.
  always_comb begin
    cap = 32'h0000_0000;
    cap[CAP_MIN_LSB +: 3] = CHUNK_SEL_MIN;
  end

  // Selector writes outside the supported range leave the stored value alone.
  always_comb begin
    cfg2_d = cfg2_q;
    cfg3_d = cfg3_q;
    chunk_sel_d = chunk_sel_q;
    chunk_sel_wr = i_wb_dat[CHUNK_SEL_LSB +: 3];
    if (wr_go && hit(i_wb_adr, IDX_CFG2)) begin
      cfg2_d = merge(cfg2_q, i_wb_dat, i_wb_sel, CFG2_WMASK);
    end
    if (wr_go && hit(i_wb_adr, IDX_CFG3)) begin
      cfg3_d = merge(cfg3_q, i_wb_dat, i_wb_sel, CFG3_WMASK);
    end
    if (wr_go && hit(i_wb_adr, IDX_CHUNK) && i_wb_sel[0]) begin
      if ((chunk_sel_wr >= CHUNK_SEL_MIN) && (chunk_sel_wr <= CHUNK_SEL_MAX)) begin
        chunk_sel_d = chunk_sel_wr;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg2_q <= CFG2_RST;
      cfg3_q <= CFG3_RST;
      chunk_sel_q <= CHUNK_SEL_RST;
    end else begin
      cfg2_q <= cfg2_d;
      cfg3_q <= cfg3_d;
      chunk_sel_q <= chunk_sel_d;
    end
  end

  // Chunk size toward the data protocol; the host keeps it stable while frames move.
  always_comb begin
    active_d = !i_generic_spi;
    bytes_d = 7'h00;
    if (!i_generic_spi) begin
      bytes_d = 7'(8'h01 << chunk_sel_q);
    end
    gap2_d = cfg2_q[CFG2_GAP2];
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bytes_q <= 7'h00;
      active_q <= 1'b0;
      gap2_q <= 1'b0;
    end else begin
      bytes_q <= bytes_d;
      active_q <= active_d;
      gap2_q <= gap2_d;
    end
  end

  assign o_chunk_bytes = bytes_q;
  assign o_chunk_active = active_q;
  assign o_port2_admit_gap_error_frames = gap2_q;

  // Two FIFOs per port are arbitrated toward the host.
  swc_arb u_arb (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_rxq(i_rxq),
    .i_ping_pong(cfg2_q[CFG2_ORDER]),
    .i_next(i_rx_next),
    .o_sel(sel),
    .o_last(last)
  );

  assign o_rx_sel = sel;

  swc_fwd u_fwd (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_frm(i_frm),
    .i_gap2_admit(gap2_q),
    .i_u1p2(cfg2_q[CFG2_U1P2]),
    .i_u2p1(cfg2_q[CFG2_U2P1]),
    .i_u1cpu(cfg3_q[CFG3_U1CPU]),
    .i_u2cpu(cfg2_q[CFG2_U2CPU]),
    .o_dec(dec)
  );

  assign o_dec = dec;

  // The decision carries no port, so the frame's port is held for one cycle.
  swc_port_t dec_port_d, dec_port_q;

  // Per-port counters of dropped frames, wrapping at their width.
  for (genvar p = 0; p < 2; p++) begin : g_drop
    logic [CNT_W-1:0] cnt_d, cnt_q;
    always_comb begin
      cnt_d = cnt_q;
      if (dec.valid && dec.drop && (dec_port_q == swc_port_t'(p))) begin
        cnt_d = cnt_q + 1'b1;
      end
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_d;
      end
    end
    assign drop_cnt[p] = cnt_q;
  end

  always_comb begin
    dec_port_d = i_frm.port;
    gaprej_d = gaprej_q;
    if (dec.valid && dec.gap_rej) begin
      gaprej_d = gaprej_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dec_port_q <= SWC_PORT1;
      gaprej_q <= '0;
    end else begin
      dec_port_q <= dec_port_d;
      gaprej_q <= gaprej_d;
    end
  end

  always_comb begin
    stat = 32'h0000_0000;
    stat[STAT_LAST] = (last == SWC_PORT2);
    stat[STAT_ACTIVE] = active_q;
    stat[STAT_DROP1_LSB +: CNT_W] = drop_cnt[0];
    stat[STAT_DROP2_LSB +: CNT_W] = drop_cnt[1];
    stat[STAT_GAPREJ_LSB +: CNT_W] = gaprej_q;
  end
endmodule : swc_top
`default_nettype wire

// file: verif/swc_props.sv
// Port-level checks of the configuration block top.
`timescale 1ns/1ps
`default_nettype none
module swc_props
  import swc_pkg::*;
(
  input wire logic i_clk, // Clock.
  input wire logic i_reset_n, // Reset.
  input wire logic i_wb_cyc, // Cycle.
  input wire logic i_wb_stb, // Strobe.
  input wire logic o_wb_ack, // Ack.
  input wire logic i_generic_spi, // Generic mode.
  input wire swc_rxq_t i_rxq, // Queues.
  input wire logic i_rx_next, // Frame request.
  input wire swc_sel_t o_rx_sel, // Selection.
  input wire swc_frm_t i_frm, // Frame.
  input wire swc_dec_t o_dec, // Decision.
  input wire logic [6:0] o_chunk_bytes, // Chunk size.
  input wire logic o_chunk_active, // Chunk mode.
  input wire logic o_port2_admit_gap_error_frames // Gap admit.
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic [1:0] hi_d, hi_q, lo_d, lo_q;
  logic unk_d, unk_q;
  always_comb begin
    hi_d = i_rxq.hi_rdy;
    lo_d = i_rxq.lo_rdy;
    unk_d = i_frm.unknown;
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {hi_q, lo_q, unk_q} <= 5'h00;
    end else begin
      {hi_q, lo_q, unk_q} <= {hi_d, lo_d, unk_d};
    end
  end
  property p_ack_once; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");
  property p_ack_answer; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack late");
  property p_chunk_size;
    !i_generic_spi |=> o_chunk_active && o_chunk_bytes inside {7'h08, 7'h10, 7'h20, 7'h40};
  endproperty
  a_chunk_size: assert property (p_chunk_size) else $error("bad chunk size");
  property p_chunk_off; i_generic_spi |=> !o_chunk_active && o_chunk_bytes == 7'h00; endproperty
  a_chunk_off: assert property (p_chunk_off) else $error("chunking in generic mode");
  property p_dec_answer; i_frm.valid |=> o_dec.valid; endproperty
  a_dec_answer: assert property (p_dec_answer) else $error("decision missing");
  property p_gap;
    i_frm.valid && i_frm.port == SWC_PORT2 && i_frm.gap_err
      |=> o_dec.gap_rej != $past(o_port2_admit_gap_error_frames);
  endproperty
  a_gap: assert property (p_gap) else $error("gap admission wrong");
  property p_unknown;
    o_dec.valid && !o_dec.gap_rej |-> (unk_q ? o_dec.drop != (o_dec.to_other || o_dec.to_cpu_lo)
      : !(o_dec.drop || o_dec.to_other || o_dec.to_cpu_lo));
  endproperty
  a_unknown: assert property (p_unknown) else $error("forwarding wrong");
  property p_sel_answer; i_rx_next && (|{i_rxq.hi_rdy, i_rxq.lo_rdy}) |=> o_rx_sel.valid; endproperty
  a_sel_answer: assert property (p_sel_answer) else $error("selection missing");
  property p_sel_source;
    o_rx_sel.valid |-> (o_rx_sel.high ? hi_q[o_rx_sel.port] : lo_q[o_rx_sel.port] && hi_q == 2'h0);
  endproperty
  a_sel_source: assert property (p_sel_source) else $error("bad queue chosen");
endmodule : swc_props
bind swc_top swc_props i_props (.i_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack,
  .i_generic_spi, .i_rxq, .i_rx_next, .o_rx_sel, .i_frm, .o_dec, .o_chunk_bytes,
  .o_chunk_active, .o_port2_admit_gap_error_frames);
`default_nettype wire

// file: verif/swc_host_model.sv
// Behavioural host controller that asks for the next receive frame.
`timescale 1ns/1ps
`default_nettype none
module swc_host_model (
  input wire logic i_clk, // Clock.
  input wire logic i_reset_n, // Reset.
  output logic o_next // One-cycle frame request.
);
  initial o_next = 1'b0;
  // Only pulls frames after an idle gap; it never rewrites the chunk selector.
  task automatic pull(input int gap);
    repeat (gap) @(posedge i_clk);
    o_next <= i_reset_n;
    @(posedge i_clk);
    o_next <= 1'b0;
  endtask : pull
endmodule : swc_host_model
`default_nettype wire

// file: verif/test_switch_host_chunk_forward_cfg.sv
// Self-checking bench of the switch configuration block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h want %h", $time, (g), (e)); end end
module test_switch_host_chunk_forward_cfg
  import swc_pkg::*;
;
  logic clk, rst_n, cyc, stb, we, ack, gspi, nxt, cact, gap2, u1c;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, c2, seed, r;
  logic [6:0] cbytes;
  swc_rxq_t rxq, qx;
  swc_sel_t rsel, es;
  swc_frm_t frm, fx;
  swc_dec_t dec, ed;
  swc_port_t last;
  logic [1:0][7:0] dcnt;
  logic [7:0] gcnt;
  int error_cnt, tests_run, csel;
  swc_top i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_generic_spi(gspi), .i_rxq(rxq), .i_rx_next(nxt), .o_rx_sel(rsel), .i_frm(frm),
    .o_dec(dec), .o_chunk_bytes(cbytes), .o_chunk_active(cact),
    .o_port2_admit_gap_error_frames(gap2));
  swc_host_model i_host (.i_clk(clk), .i_reset_n(rst_n), .o_next(nxt));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic close_out();
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    {cyc, stb} <= 2'h0;
    if (ack !== 1'b1) begin
      error_cnt++;
      close_out();
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    wb(1'b0, a, 32'h0);
    `CHK(q & m, e)
  endtask : rd
  function automatic swc_dec_t exp_dec(swc_frm_t f, logic [31:0] c, logic u);
    logic p2;
    logic fwd;
    logic cpu;
    p2 = f.port == SWC_PORT2;
    fwd = p2 ? c[CFG2_U2P1] : c[CFG2_U1P2];
    cpu = p2 ? c[CFG2_U2CPU] : u;
    exp_dec = '0;
    exp_dec.valid = 1'b1;
    if (p2 && f.gap_err && !c[CFG2_GAP2]) exp_dec[3:2] = 2'h3;
    else if (f.unknown) exp_dec[2:0] = {!(fwd || cpu), fwd, cpu};
  endfunction : exp_dec
  function automatic swc_sel_t exp_sel(swc_rxq_t x, logic pp, swc_port_t lp);
    logic [1:0] rd_v;
    logic [1:0][FILL_W-1:0] fl;
    exp_sel = '0;
    exp_sel.high = |x.hi_rdy;
    rd_v = exp_sel.high ? x.hi_rdy : x.lo_rdy;
    fl = exp_sel.high ? x.hi_fill : x.lo_fill;
    exp_sel.valid = |rd_v;
    if (rd_v == 2'h2) exp_sel.port = SWC_PORT2;
    else if (rd_v == 2'h3 && pp) exp_sel.port = lp == SWC_PORT1 ? SWC_PORT2 : SWC_PORT1;
    else if (rd_v == 2'h3 && fl[1] > fl[0]) exp_sel.port = SWC_PORT2;
  endfunction : exp_sel
  initial begin
    {cyc, stb, we, gspi, adr, wdat, rxq, frm, dcnt, gcnt} = '0;
    {sel, rst_n, error_cnt, tests_run, seed} = {4'hF, 1'b0, 64'h0, 32'h2E93};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h10, 32'h6, '1);
    rd(8'h18, CFG2_RST, '1);
    rd(8'hFC, 32'h0, '1);
    `CHK({gap2, cbytes}, 8'h40)
    sel <= 4'hE;
    wb(1'b1, 8'h10, 32'h3);
    sel <= 4'hF;
    wb(1'b1, 8'h08, 32'h0);
    rd(8'h08, 32'h3, 32'h7);
    csel = 6;
    for (int n = 2; n <= 7; n++) begin
      wb(1'b1, 8'h10, 32'(n));
      if (n >= CHUNK_SEL_MIN && n <= CHUNK_SEL_MAX) csel = n;
      rd(8'h10, 32'(csel), '1);
      `CHK(cbytes, 7'(1 << csel))
    end
    gspi <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({cact, cbytes}, 8'h00)
    gspi <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({cact, cbytes}, 8'hC0)
    for (int k = 0; k < 24; k++) begin
      c2 = $random(seed);
      u1c = c2[31];
      wb(1'b1, 8'h18, c2);
      wb(1'b1, 8'h14, {29'h0, u1c, 2'h0});
      rd(8'h18, c2 & CFG2_WMASK, '1);
      `CHK(gap2, c2[CFG2_GAP2])
      for (int f = 0; f < 8; f++) begin
        fx = {1'b1, f[2], f[1], f[0]};
        frm <= fx;
        @(posedge clk);
        frm <= '0;
        @(posedge clk);
        ed = exp_dec(fx, c2, u1c);
        `CHK(dec, ed)
        dcnt[fx.port] = dcnt[fx.port] + 8'(ed.drop);
        gcnt = gcnt + 8'(ed.gap_rej);
      end
    end
    last = SWC_PORT2;
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, 8'h18, 32'(m) << CFG2_ORDER);
      for (int k = 0; k < 48; k++) begin
        r = $random(seed);
        qx = {r[1:0] & {2{r[8]}}, r[3:2], 12'(r[5:4]), 12'(r[7:6]), 12'(r[10:9]), 12'(r[12:11])};
        rxq <= qx;
        i_host.pull(k % 3 + 1);
        @(posedge clk);
        es = exp_sel(qx, m[0], last);
        `CHK(rsel.valid, es.valid)
        if (es.valid) begin
          `CHK(rsel, es)
          last = es.port;
        end
      end
    end
    rd(8'h1C, {gcnt, dcnt[1], dcnt[0], 6'h00, 1'b1, last == SWC_PORT2}, '1);
    close_out();
  end
endmodule : test_switch_host_chunk_forward_cfg
`default_nettype wire
